// ---- hdl/tmr_regs.sv ----
// Purpose: APB register block, prescalers and event flags of a dual
//          8-bit down-counting timer
// Assumes: oscillator clocks arrive as levels synchronous to sys_clk;
//          counter core supplies live counts and underflow pulses
// Notes:   zero-wait APB slave, answer in the first access cycle
`timescale 1ns/1ps
`default_nettype none
module tmr_regs
  import tmr_regs_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic                              sys_clk,
  input  wire logic                              arst_n,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [tmr_regs_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                       pwdata,
  input  wire logic [3:0]                        pstrb,
  output var  logic [31:0]                       prdata,
  output var  logic                              pready,
  output var  logic                              pslverr,
  input  wire logic                              low_speed_osc_clock,
  input  wire logic                              high_speed_osc_clock,
  input  wire tmr_regs_pkg::core_status_s        core_status,
  output var  tmr_regs_pkg::core_cfg_s           core_cfg,
  output var  logic [1:0]                        presc_tick,
  output var  logic [1:0]                        match_pulse,
  output var  logic [1:0]                        match_irq,
  output var  logic [1:0]                        underflow_irq
);
  import tmr_regs_pkg::*;

  function automatic logic [7:0] ratio_last(input logic [1:0] ratio);
    logic [7:0] r;
    r = DIV1_LAST;
    case (ratio)
      2'h1:    r = DIV4_LAST;
      2'h2:    r = DIV32_LAST;
      2'h3:    r = DIV256_LAST;
      default: r = DIV1_LAST;
    endcase
    return r;
  endfunction : ratio_last

  // register state
  logic             chain_q;
  logic             evt_mode_q;
  logic [1:0]       src_sel_q;
  logic [1:0]       t0_ratio_q;
  logic [1:0]       t1_ratio_q;
  logic [3:0]       t1_reload_upper_q;
  logic [CNT_W-1:0] t0_match_value_q;
  logic [CNT_W-1:0] t1_match_value_q;
  logic [1:0]       pwm_en_q;
  logic [1:0]       match_en_q;
  logic [1:0]       uflow_en_q;
  logic [1:0]       match_flag_q;
  logic [1:0]       uflow_flag_q;
  logic [1:0]       match_flag_d;
  logic [1:0]       uflow_flag_d;
  logic [3:0]       t0_hold_q;
  logic [3:0]       t1_hold_q;

  // bus decode
  logic [15:0]      idx;
  logic             wr_acc;
  logic             rd_acc;
  logic [3:0]       wnib;
  logic [31:0]      rd_value;
  logic             mapped;

  assign idx    = paddr[ADDR_W-1:2];
  assign wr_acc = psel && penable && pready && pwrite && pstrb[0];
  assign rd_acc = psel && !penable && !pwrite;
  assign wnib   = pwdata[3:0];

  // single wait-free access: answer prepared during setup
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    mapped   = 1'b1;
    if (idx == IDX_CTRL) begin
      rd_value[CTRL_CHAIN_BIT] = chain_q;
      rd_value[CTRL_EVENT_BIT] = evt_mode_q;
    end else if (idx == IDX_SRC_SEL) begin
      rd_value[1:0] = src_sel_q;
    end else if (idx == IDX_T0_PRESC) begin
      rd_value[3:2] = t0_ratio_q;
    end else if (idx == IDX_T1_PRESC) begin
      rd_value[3:2] = t1_ratio_q;
    end else if (idx == IDX_T1_RLD_HI) begin
      rd_value[3:0] = t1_reload_upper_q;
    end else if (idx == IDX_T0_CNT_LO) begin
      rd_value[3:0] = core_status.t0_count[3:0];
    end else if (idx == IDX_T0_CNT_HI) begin
      rd_value[3:0] = t0_hold_q;
    end else if (idx == IDX_T1_CNT_LO) begin
      rd_value[3:0] = core_status.t1_count[3:0];
    end else if (idx == IDX_T1_CNT_HI) begin
      rd_value[3:0] = t1_hold_q;
    end else if (idx == IDX_T0_MATCH_LO) begin
      rd_value[3:0] = t0_match_value_q[3:0];
    end else if (idx == IDX_T0_MATCH_HI) begin
      rd_value[3:0] = t0_match_value_q[7:4];
    end else if (idx == IDX_T1_MATCH_LO) begin
      rd_value[3:0] = t1_match_value_q[3:0];
    end else if (idx == IDX_T1_MATCH_HI) begin
      rd_value[3:0] = t1_match_value_q[7:4];
    end else if (idx == IDX_PWM_SEL) begin
      rd_value[1:0] = pwm_en_q;
    end else if (idx == IDX_MATCH_EN) begin
      rd_value[1:0] = match_en_q;
    end else if (idx == IDX_UFLOW_EN) begin
      rd_value[1:0] = uflow_en_q;
    end else if (idx == IDX_MATCH_FLAG) begin
      rd_value[1:0] = match_flag_q;
    end else if (idx == IDX_UFLOW_FLAG) begin
      rd_value[1:0] = uflow_flag_q;
    end else begin
      mapped = 1'b0;
    end
  end

  // data and error are latched in setup so they stand for the access cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_value;
      pslverr <= !mapped;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // high nibble frozen on low read
  // taken at setup with prdata, so a live count cannot tear the pair
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      t0_hold_q <= NIBBLE_RESET;
      t1_hold_q <= NIBBLE_RESET;
    end else if (rd_acc) begin
      if (idx == IDX_T0_CNT_LO) begin
        t0_hold_q <= core_status.t0_count[7:4];
      end
      if (idx == IDX_T1_CNT_LO) begin
        t1_hold_q <= core_status.t1_count[7:4];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chain_q    <= 1'b0;
      evt_mode_q <= 1'b0;
    end else if (wr_acc && idx == IDX_CTRL) begin
      chain_q    <= wnib[CTRL_CHAIN_BIT];
      evt_mode_q <= wnib[CTRL_EVENT_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      src_sel_q  <= PAIR_RESET;
      t0_ratio_q <= PAIR_RESET;
      t1_ratio_q <= PAIR_RESET;
    end else if (wr_acc) begin
      if (idx == IDX_SRC_SEL) begin
        src_sel_q <= wnib[1:0];
      end
      if (idx == IDX_T0_PRESC) begin
        t0_ratio_q <= wnib[RATIO_LSB+1:RATIO_LSB];
      end
      if (idx == IDX_T1_PRESC) begin
        t1_ratio_q <= wnib[RATIO_LSB+1:RATIO_LSB];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      t1_reload_upper_q <= NIBBLE_RESET;
      t0_match_value_q  <= BYTE_RESET;
      t1_match_value_q  <= BYTE_RESET;
    end else if (wr_acc) begin
      if (idx == IDX_T1_RLD_HI) begin
        t1_reload_upper_q <= wnib;
      end
      if (idx == IDX_T0_MATCH_LO) begin
        t0_match_value_q[3:0] <= wnib;
      end
      if (idx == IDX_T0_MATCH_HI) begin
        t0_match_value_q[7:4] <= wnib;
      end
      if (idx == IDX_T1_MATCH_LO) begin
        t1_match_value_q[3:0] <= wnib;
      end
      if (idx == IDX_T1_MATCH_HI) begin
        t1_match_value_q[7:4] <= wnib;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_en_q   <= PAIR_RESET;
      match_en_q <= PAIR_RESET;
      uflow_en_q <= PAIR_RESET;
    end else if (wr_acc) begin
      if (idx == IDX_PWM_SEL) begin
        pwm_en_q <= wnib[1:0];
      end
      if (idx == IDX_MATCH_EN) begin
        match_en_q <= wnib[1:0];
      end
      if (idx == IDX_UFLOW_EN) begin
        uflow_en_q <= wnib[1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_cfg <= '0;
    end else begin
      core_cfg.chain_sixteen_bit   <= chain_q;
      core_cfg.t0_event_count_mode <= evt_mode_q;
      core_cfg.pwm_enable          <= pwm_en_q;
      core_cfg.t1_reload_upper     <= t1_reload_upper_q;
    end
  end

  // prescalers: oscillator inputs are sampled, so an edge is one cycle
  logic             lo_prev_q;
  logic             hi_prev_q;
  logic             lo_rise;
  logic             hi_rise;
  logic [1:0]       src_edge;
  logic [1:0]       presc_live;
  logic [7:0]       div_cnt_q [2];
  logic [1:0]       ratio_sel [2];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_prev_q <= 1'b0;
      hi_prev_q <= 1'b0;
    end else begin
      lo_prev_q <= low_speed_osc_clock;
      hi_prev_q <= high_speed_osc_clock;
    end
  end

  assign lo_rise      = low_speed_osc_clock && !lo_prev_q;
  assign hi_rise      = high_speed_osc_clock && !hi_prev_q;
  assign ratio_sel[0] = t0_ratio_q;
  assign ratio_sel[1] = t1_ratio_q;
  // source select ignored by timer 0 in event mode and by timer 1 when chained
  // in those modes the prescaler is parked, since its output is unused
  assign presc_live[0] = !evt_mode_q;
  assign presc_live[1] = !chain_q;
  assign src_edge[0] = src_sel_q[0] ? hi_rise : lo_rise;
  assign src_edge[1] = src_sel_q[1] ? hi_rise : lo_rise;

  for (genvar t = 0; t < 2; t++) begin : g_presc
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        div_cnt_q[t]  <= BYTE_RESET;
        presc_tick[t] <= 1'b0;
      end else if (!presc_live[t]) begin
        div_cnt_q[t]  <= BYTE_RESET;
        presc_tick[t] <= 1'b0;
      end else if (src_edge[t]) begin
        if (div_cnt_q[t] >= ratio_last(ratio_sel[t])) begin
          div_cnt_q[t]  <= BYTE_RESET;
          presc_tick[t] <= 1'b1;
        end else begin
          div_cnt_q[t]  <= div_cnt_q[t] + 8'h01;
          presc_tick[t] <= 1'b0;
        end
      end else begin
        presc_tick[t] <= 1'b0;
      end
    end
  end

  // compare: a pulse on entering equality, so a stalled count fires once
  logic [1:0]       eq_now;
  logic [1:0]       eq_prev_q;
  logic [1:0]       match_hit;

  assign eq_now[0] = pwm_en_q[0] &&
                     (core_status.t0_count == t0_match_value_q);
  assign eq_now[1] = pwm_en_q[1] && !chain_q &&
                     (core_status.t1_count == t1_match_value_q);
  assign match_hit = eq_now & ~eq_prev_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      eq_prev_q   <= PAIR_RESET;
      match_pulse <= PAIR_RESET;
    end else begin
      eq_prev_q   <= eq_now;
      match_pulse <= match_hit;
    end
  end

  always_comb begin
    match_flag_d = match_flag_q;
    uflow_flag_d = uflow_flag_q;
    if (wr_acc && idx == IDX_MATCH_FLAG) begin
      match_flag_d = match_flag_q & ~wnib[1:0];
    end
    if (wr_acc && idx == IDX_UFLOW_FLAG) begin
      uflow_flag_d = uflow_flag_q & ~wnib[1:0];
    end
    match_flag_d = match_flag_d | match_hit;
    uflow_flag_d = uflow_flag_d |
      {core_status.t1_underflow, core_status.t0_underflow};
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      match_flag_q  <= PAIR_RESET;
      uflow_flag_q  <= PAIR_RESET;
      match_irq     <= PAIR_RESET;
      underflow_irq <= PAIR_RESET;
    end else begin
      match_flag_q  <= match_flag_d;
      uflow_flag_q  <= uflow_flag_d;
      match_irq     <= match_flag_d & match_en_q;
      underflow_irq <= uflow_flag_d & uflow_en_q;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  chk_irq_gate_match: assert property (
    match_irq == (match_flag_q & $past(match_en_q)))
    else $error("match request not flag and enable");
  chk_uflow_flag_set: assert property (
    core_status.t0_underflow |=> uflow_flag_q[0])
    else $error("underflow flag not set");
  chk_uflow_flag_clear: assert property (
    wr_acc && idx == IDX_UFLOW_FLAG && wnib[0] &&
    !core_status.t0_underflow |=> !uflow_flag_q[0])
    else $error("underflow flag not cleared");
  chk_event_mode_tick: assert property (
    evt_mode_q |=> !presc_tick[0])
    else $error("timer 0 prescaler ticked in event mode");
  chk_chain_mode_tick: assert property (
    chain_q |=> !presc_tick[1])
    else $error("timer 1 prescaler ticked while chained");
  chk_div1_tick: assert property (
    !evt_mode_q && t0_ratio_q == 2'h0 && !src_sel_q[0] && lo_rise
    |=> presc_tick[0])
    else $error("divide by one missed a tick");
  chk_div4_spacing: assert property (
    $rose(presc_tick[0]) && t0_ratio_q == 2'h1 && $stable(t0_ratio_q)
    && !evt_mode_q |=> !presc_tick[0] [*2])
    else $error("divide by four ticked too soon");
  chk_snapshot_hold: assert property (
    rd_acc && idx == IDX_T0_CNT_LO
    |=> t0_hold_q == $past(core_status.t0_count[7:4]))
    else $error("high nibble not frozen");
  chk_apb_ready: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single access cycle");
  chk_pwm_match_off: assert property (
    !pwm_en_q[0] |=> !match_pulse[0])
    else $error("match without pwm mode");
  chk_match_flag_set: assert property (
    match_hit[0] |=> match_flag_q[0])
    else $error("match flag not set");
endmodule : tmr_regs
`default_nettype wire

// ---- inc/tmr_regs_pkg.sv ----
// Purpose: constants and carriers for the dual timer register block
// Assumes: nibble registers, one per 32-bit APB word at index*4
// Notes:   offsets are register indices; byte address is four times them
package tmr_regs_pkg;
  localparam int          ADDR_W          = 18;
  localparam logic [15:0] IDX_CTRL        = 16'hffc0;
  localparam logic [15:0] IDX_SRC_SEL     = 16'hffc2;
  localparam logic [15:0] IDX_T0_PRESC    = 16'hffc3;
  localparam logic [15:0] IDX_T1_PRESC    = 16'hffc4;
  localparam logic [15:0] IDX_T1_RLD_HI   = 16'hffc9;
  localparam logic [15:0] IDX_T0_CNT_LO   = 16'hffcc;
  localparam logic [15:0] IDX_T0_CNT_HI   = 16'hffcd;
  localparam logic [15:0] IDX_T1_CNT_LO   = 16'hffce;
  localparam logic [15:0] IDX_T1_CNT_HI   = 16'hffcf;
  localparam logic [15:0] IDX_T0_MATCH_LO = 16'hffd2;
  localparam logic [15:0] IDX_T0_MATCH_HI = 16'hffd3;
  localparam logic [15:0] IDX_T1_MATCH_LO = 16'hffd4;
  localparam logic [15:0] IDX_T1_MATCH_HI = 16'hffd5;
  localparam logic [15:0] IDX_PWM_SEL     = 16'hffd8;
  localparam logic [15:0] IDX_MATCH_EN    = 16'hffe0;
  localparam logic [15:0] IDX_UFLOW_EN    = 16'hffe1;
  localparam logic [15:0] IDX_MATCH_FLAG  = 16'hfff0;
  localparam logic [15:0] IDX_UFLOW_FLAG  = 16'hfff1;
  // control and prescaler register field positions
  localparam int          CTRL_CHAIN_BIT  = 3;
  localparam int          CTRL_EVENT_BIT  = 2;
  localparam int          RATIO_LSB       = 2;
  localparam logic [3:0]  NIBBLE_RESET    = 4'h0;
  localparam logic [1:0]  PAIR_RESET      = 2'h0;
  localparam logic [7:0]  BYTE_RESET      = 8'h00;
  // prescaler terminal counts for /1, /4, /32, /256
  localparam logic [7:0]  DIV1_LAST       = 8'h00;
  localparam logic [7:0]  DIV4_LAST       = 8'h03;
  localparam logic [7:0]  DIV32_LAST      = 8'h1f;
  localparam logic [7:0]  DIV256_LAST     = 8'hff;

  typedef struct packed {
    logic [7:0] t1_count;
    logic [7:0] t0_count;
    logic       t1_underflow;
    logic       t0_underflow;
  } core_status_s;

  typedef struct packed {
    logic       chain_sixteen_bit;
    logic       t0_event_count_mode;
    logic [1:0] pwm_enable;
    logic [3:0] t1_reload_upper;
  } core_cfg_s;
endpackage : tmr_regs_pkg

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the dual timer register block
// Assumes: zero-wait apb slave; byte address is register index times four
// Notes:   data from a fixed-seed xorshift; oscillators toggled as levels
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tmr_regs_pkg::*;
  logic               sys_clk = 1'b0;
  logic               arst_n = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [ADDR_W-1:0]  paddr = '0;
  logic [31:0]        pwdata = '0;
  logic [3:0]         pstrb = 4'hf;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               lo_osc = 1'b0;
  logic               hi_osc = 1'b0;
  core_status_s       core_status = '0;
  core_cfg_s          core_cfg;
  logic [1:0]         presc_tick;
  logic [1:0]         match_pulse;
  logic [1:0]         match_irq;
  logic [1:0]         underflow_irq;
  int                 mismatches = 0;
  int                 num_checks = 0;
  logic [31:0]        seed = 32'h0832;
  logic [31:0]        rd;
  logic               err;
  // first twelve are read-write, in the order of rw_mask
  logic [15:0] all_idx [18] = '{IDX_CTRL, IDX_SRC_SEL, IDX_T0_PRESC,
    IDX_T1_PRESC, IDX_T1_RLD_HI, IDX_T0_MATCH_LO, IDX_T0_MATCH_HI,
    IDX_T1_MATCH_LO, IDX_T1_MATCH_HI, IDX_PWM_SEL, IDX_MATCH_EN,
    IDX_UFLOW_EN, IDX_T0_CNT_LO, IDX_T0_CNT_HI, IDX_T1_CNT_LO,
    IDX_T1_CNT_HI, IDX_MATCH_FLAG, IDX_UFLOW_FLAG};
  logic [3:0]  rw_mask [12] = '{4'hc, 4'h3, 4'hc, 4'hc, 4'hf, 4'hf,
    4'hf, 4'hf, 4'hf, 4'h3, 4'h3, 4'h3};

  tmr_regs dut (
    .sys_clk              (sys_clk),
    .arst_n               (arst_n),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .pstrb                (pstrb),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .low_speed_osc_clock  (lo_osc),
    .high_speed_osc_clock (hi_osc),
    .core_status          (core_status),
    .core_cfg             (core_cfg),
    .presc_tick           (presc_tick),
    .match_pulse          (match_pulse),
    .match_irq            (match_irq),
    .underflow_irq        (underflow_irq)
  );

  always #25 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic int exp_ticks(int edges, logic [1:0] ratio);
    case (ratio)
      2'd0: return edges;
      2'd1: return edges / 4;
      2'd2: return edges / 32;
      default: return edges / 256;
    endcase
  endfunction : exp_ticks

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr_en, input logic [15:0] idx,
                     input logic [31:0] wd, input logic [3:0] st);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      $display("apb timeout");
      mismatches++;
      finish_test();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 4'hf);
  endtask : wr

  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, rnd(), 4'hf);
    check(rd, exp);
  endtask : rdchk

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
  endtask : do_reset

  // low-speed source: 256 rising edges, high-speed: 512, then a quiet tail
  task automatic run_osc(output int c0, output int c1);
    c0 = 0;
    c1 = 0;
    for (int i = 0; i < 1032; i++) begin
      @(posedge sys_clk);
      c0 += presc_tick[0];
      c1 += presc_tick[1];
      lo_osc <= (i < 1024) && i[1];
      hi_osc <= (i < 1024) && i[0];
    end
  endtask : run_osc

  initial begin
    logic [31:0] v;
    logic [1:0]  m;
    int          c0;
    int          c1;
    int          n;
    do_reset();
    foreach (all_idx[i]) rdchk(all_idx[i], 32'h0);
    apb(1'b1, 16'hffc5, rnd(), 4'hf);
    check({31'h0, err}, 32'h1);
    rdchk(16'hffc5, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test reset and unmapped done");
    // readback with unused bits masked; a write without pstrb[0] is dropped
    repeat (2) begin
      for (int i = 0; i < 12; i++) begin
        v = rnd();
        wr(all_idx[i], v);
        apb(1'b1, all_idx[i], ~v, 4'he);
        rdchk(all_idx[i], {28'h0, v[3:0] & rw_mask[i]});
      end
    end
    wr(IDX_CTRL, 32'hc);
    wr(IDX_PWM_SEL, 32'h2);
    wr(IDX_T1_RLD_HI, 32'h5);
    repeat (2) @(posedge sys_clk);
    check({24'h0, core_cfg}, 32'he5);
    $display("test readback done");
    do_reset();
    repeat (3) begin
      v = rnd();
      core_status.t0_count <= v[7:0];
      core_status.t1_count <= v[15:8];
      wr(IDX_T0_CNT_LO, ~v);
      rdchk(IDX_T0_CNT_LO, {28'h0, v[3:0]});
      rdchk(IDX_T1_CNT_LO, {28'h0, v[11:8]});
      core_status.t0_count <= v[23:16];
      core_status.t1_count <= v[31:24];
      rdchk(IDX_T0_CNT_HI, {28'h0, v[7:4]});
      rdchk(IDX_T1_CNT_HI, {28'h0, v[15:12]});
    end
    $display("test count snapshot done");
    for (int t = 0; t < 2; t++) begin
      m = t ? 2'b10 : 2'b01;
      do_reset();
      @(posedge sys_clk);
      {core_status.t1_underflow, core_status.t0_underflow} <= m;
      @(posedge sys_clk);
      {core_status.t1_underflow, core_status.t0_underflow} <= 2'b00;
      rdchk(IDX_UFLOW_FLAG, {30'h0, m});
      check({30'h0, underflow_irq}, 32'h0);
      wr(IDX_UFLOW_EN, {30'h0, m});
      repeat (2) @(posedge sys_clk);
      check({30'h0, underflow_irq}, {30'h0, m});
      wr(IDX_UFLOW_FLAG, {30'h0, ~m});
      rdchk(IDX_UFLOW_FLAG, {30'h0, m});
      wr(IDX_UFLOW_FLAG, {30'h0, m});
      rdchk(IDX_UFLOW_FLAG, 32'h0);
      check({30'h0, underflow_irq}, 32'h0);
      // compare match, first with pwm off where no match may appear
      v = rnd();
      core_status.t0_count <= ~v[7:0];
      core_status.t1_count <= ~v[7:0];
      wr(t ? IDX_T1_MATCH_LO : IDX_T0_MATCH_LO, {28'h0, v[3:0]});
      wr(t ? IDX_T1_MATCH_HI : IDX_T0_MATCH_HI, {28'h0, v[7:4]});
      wr(IDX_MATCH_EN, {30'h0, m});
      core_status.t0_count <= v[7:0];
      core_status.t1_count <= v[7:0];
      repeat (4) @(posedge sys_clk);
      rdchk(IDX_MATCH_FLAG, 32'h0);
      core_status.t0_count <= ~v[7:0];
      core_status.t1_count <= ~v[7:0];
      wr(IDX_PWM_SEL, {30'h0, m});
      core_status.t0_count <= v[7:0];
      core_status.t1_count <= v[7:0];
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (match_pulse === 2'b00 && n < 10);
      check({30'h0, match_pulse}, {30'h0, m});
      repeat (2) @(posedge sys_clk);
      check({30'h0, match_irq}, {30'h0, m});
      wr(IDX_MATCH_FLAG, 32'h0);
      rdchk(IDX_MATCH_FLAG, {30'h0, m});
      wr(IDX_MATCH_FLAG, {30'h0, m});
      rdchk(IDX_MATCH_FLAG, 32'h0);
    end
    $display("test flags done");
    // timer 0 and timer 1 take opposite sources in each run
    for (int r = 0; r < 4; r++) begin
      for (int s = 0; s < 2; s++) begin
        do_reset();
        wr(IDX_SRC_SEL, s ? 32'h1 : 32'h2);
        wr(IDX_T0_PRESC, r << 2);
        wr(IDX_T1_PRESC, r << 2);
        run_osc(c0, c1);
        check(c0, exp_ticks(s ? 512 : 256, 2'(r)));
        check(c1, exp_ticks(s ? 256 : 512, 2'(r)));
      end
    end
    do_reset();
    wr(IDX_CTRL, 32'hc);
    wr(IDX_SRC_SEL, 32'h3);
    run_osc(c0, c1);
    check(c0, 32'h0);
    check(c1, 32'h0);
    $display("test prescaler done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
